// ---- core/scdf_pkg.sv ----
// scdf_pkg: register map, field positions and timing for the channel flag bank
// assumes one 250 MHz clock domain and an apb register port
`default_nettype none
package scdf_pkg;
  localparam int unsigned NUM_CHAN        = 32;
  localparam int unsigned CHAN_W          = 5;
  localparam int unsigned BUF_MAX_BYTES   = 1536;
  localparam int unsigned BUF_SMALL_BYTES = 720;
  localparam int unsigned LEN_W           = 11;
  // apb byte offsets
  localparam logic [11:0] OFS_GLOBAL  = 12'h000;
  localparam logic [11:0] OFS_CHANREG = 12'h004;
  localparam logic [11:0] OFS_CMD     = 12'h008;
  localparam logic [11:0] OFS_TIMEOUT = 12'h00C;
  localparam logic [11:0] OFS_CONFIG  = 12'h010;
  localparam logic [11:0] OFS_CFLAGS  = 12'h100;
  localparam logic [11:0] OFS_DETAIL  = 12'h200;
  // global flag positions
  localparam int unsigned GF_SEND_BUSY = 0;
  localparam int unsigned GF_RX_DATA   = 1;
  localparam int unsigned GF_CONN_EVT  = 2;
  localparam int unsigned GF_LINK_UP   = 6;
  // channel flag positions
  localparam int unsigned CF_RX_ERR  = 0;
  localparam int unsigned CF_TX_ACT  = 1;
  localparam int unsigned CF_TX_ERR  = 2;
  localparam int unsigned CF_CONN    = 3;
  localparam int unsigned CF_NOTDONE = 4;
  // detail register masks and bits
  localparam logic [31:0] DET_RX_MASK = 32'h0000_F501;
  localparam logic [31:0] DET_TX_MASK = 32'hF080_0000;
  localparam logic [31:0] DET_MASK    = 32'hF080_F501;
  localparam int unsigned DB_RD_TIMEOUT = 0;
  localparam int unsigned DB_OVERSIZE   = 8;
  localparam int unsigned DB_TX_ABSENT  = 23;
  localparam int unsigned DB_TX_BADPORT = 29;
  localparam int unsigned DB_TX_NOCONN  = 30;
  localparam int unsigned DB_TX_ILLEGAL = 31;
  // command codes
  localparam logic [1:0] CMD_RECEIVE = 2'h1;
  localparam logic [1:0] CMD_GETEVT  = 2'h2;
  // timing
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned RD_TIMEOUT_MS  = 1000;
  localparam int unsigned CYC_PER_MS     = CLK_MHZ * 1000;
  localparam logic [15:0] TIMEOUT_RESET  = 16'h03E8;
endpackage
`default_nettype wire

// ---- core/scdf_ms_tick.sv ----
// scdf_ms_tick: one-cycle pulse once per millisecond
// assumes pclk at the package rate
`default_nettype none
module scdf_ms_tick
  import scdf_pkg::*;
#(
  parameter int unsigned CYC_PER_TICK = CYC_PER_MS
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  output logic      tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  always_comb begin
    next_cnt = cnt + 32'h1;
    if (cnt >= CYC_PER_TICK - 1) begin
      next_cnt = '0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (clk_en) begin
      cnt <= next_cnt;
    end
  end
  assign tick = clk_en && (cnt >= CYC_PER_TICK - 1);
endmodule
`default_nettype wire

// ---- core/scdf_chan_diag.sv ----
// scdf_chan_diag: per-channel sticky detail register and its flags
// assumes error pulses from the socket engine on the same clock
`default_nettype none
module scdf_chan_diag
  import scdf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic [31:0] err_set,
  input  wire logic        clr_we,
  input  wire logic [31:0] clr_mask,
  output logic [31:0]      detail,
  output logic             rx_error_summary,
  output logic             tx_error_summary
);
  logic [31:0] next_detail;
  always_comb begin
    // set wins over clear; unused bits stay zero
    next_detail = detail & ~(clr_we ? clr_mask : 32'h0000_0000);   // [R19]
    next_detail = (next_detail | err_set) & DET_MASK;               // [R21]
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detail <= 32'h0000_0000;
    end else if (clk_en) begin
      detail <= next_detail;
    end
  end
  assign rx_error_summary = |(detail & DET_RX_MASK);                // [R12] [R17]
  assign tx_error_summary = |(detail & DET_TX_MASK);                // [R13] [R18]
endmodule
`default_nettype wire

// ---- core/scdf_top.sv ----
// scdf_top: global and per-channel flags, shared channel register, apb slave
// assumes socket engine pulses on pclk; link pin is asynchronous
// Notes on behaviour
// R1 - software channels 1-10, 11-19 reserved
// R2 - data and event flags never both set
// R3 - one shared register names pending channel
// R4 - software consumes only its own channel
// R5 - send busy blocks sends on all channels
// R6 - receive flag high while telegram waits
// R7 - receive command frees mailbox, next advances
// R8 - transfers limited to 1536 or 720 bytes
// R9 - channel register updates right after receive
// R10 - connection event flag requests event fetch
// R11 - link flag follows physical link
// R12 - rx summary falls when rx bits clear
// R13 - tx summary falls when tx bits clear
// R14 - tx active refuses send, connect, disconnect
// R15 - connected flag follows tcp connection
// R16 - not-done set on failure, cleared on success
// R17 - receiver detail bit positions
// R18 - transmitter detail bit positions
// R19 - detail bits sticky until software clears
// R20 - unread telegram dropped after read timeout
// R21 - unused bits read zero, ignore writes
`default_nettype none
module scdf_top
  import scdf_pkg::*;
#(
  parameter int unsigned CYC_PER_TICK = CYC_PER_MS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              link_pin,
  input  wire logic              rx_valid,
  input  wire logic [CHAN_W-1:0] rx_chan,
  input  wire logic [LEN_W:0]    rx_len,
  output logic                   rx_ready,
  input  wire logic              evt_valid,
  input  wire logic [CHAN_W-1:0] evt_chan,
  output logic                   evt_ready,
  input  wire logic              tx_req,
  input  wire logic [CHAN_W-1:0] tx_chan,
  input  wire logic [LEN_W:0]    tx_len,
  input  wire logic              tx_ctl,
  output logic                   tx_accept,
  input  wire logic              tx_done,
  input  wire logic              tx_fail,
  input  wire logic [NUM_CHAN-1:0] conn_state,
  input  wire logic [NUM_CHAN-1:0] rx_err_evt,
  input  wire logic [NUM_CHAN-1:0] tx_dest_evt,
  output logic                   rx_consume,
  output logic                   rx_drop
);
  ////////////////////////////////////////////////////////////////////////////
  // link pin synchroniser
  logic link_s1, link_s2, link_up_flag;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_s1 <= 1'b0;
      link_s2 <= 1'b0;
    end else if (clk_en) begin
      link_s1 <= link_pin;
      link_s2 <= link_s1;
    end
  end
  assign link_up_flag = link_s2;                                    // [R11]
  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic acc, wr, cmd_wr;
  logic hit_cflags, hit_detail, word_ok;
  logic [CHAN_W-1:0] sel_ch;
  assign acc = psel && penable && clk_en;
  assign wr  = acc && pwrite;
  assign pready = 1'b1;
  assign sel_ch     = paddr[CHAN_W+1:2];
  assign word_ok    = (paddr[1:0] == 2'h0) && (paddr[7] == 1'b0);
  assign hit_cflags = word_ok && (paddr[11:8] == OFS_CFLAGS[11:8]);
  assign hit_detail = word_ok && (paddr[11:8] == OFS_DETAIL[11:8]);
  assign cmd_wr = wr && (paddr == OFS_CMD);
  ////////////////////////////////////////////////////////////////////////////
  // mailbox state: idle, data pending, event pending
  typedef enum logic [1:0] {SCDF_IDLE, SCDF_DATA, SCDF_EVT} scdf_mbox_t;
  scdf_mbox_t          mbox, next_mbox;
  logic [CHAN_W-1:0]   pending_channel_reg, next_pending_channel_reg;
  logic [15:0]         timeout_ms, next_timeout_ms, age_ms, next_age_ms;
  logic                small_buf, next_small_buf, tick, rx_big, expired;
  logic [NUM_CHAN-1:0] timeout_hit, oversize_hit;
  logic [LEN_W:0]      buf_lim;
  assign buf_lim = small_buf ? (LEN_W+1)'(BUF_SMALL_BYTES) : (LEN_W+1)'(BUF_MAX_BYTES); // [R8]
  assign rx_big = rx_len > buf_lim;
  scdf_ms_tick #(
    .CYC_PER_TICK (CYC_PER_TICK)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .tick    (tick)
  );
  assign expired = (mbox == SCDF_DATA) && tick && (age_ms + 16'h1 >= timeout_ms);
  always_comb begin
    next_mbox                = mbox;
    next_pending_channel_reg = pending_channel_reg;
    next_age_ms              = age_ms;
    next_timeout_ms          = timeout_ms;
    next_small_buf           = small_buf;
    rx_ready                 = 1'b0;
    evt_ready                = 1'b0;
    rx_consume               = 1'b0;
    rx_drop                  = 1'b0;
    timeout_hit              = '0;
    oversize_hit             = '0;
    if (wr && paddr == OFS_TIMEOUT) begin
      next_timeout_ms = pwdata[15:0];
    end
    if (wr && paddr == OFS_CONFIG) begin
      next_small_buf = pwdata[0];
    end
    if (mbox == SCDF_DATA && tick) begin
      next_age_ms = age_ms + 16'h1;
    end
    case (mbox)
      SCDF_IDLE: begin
        // data has priority; only one pending item at a time [R2]
        if (rx_valid && clk_en) begin
          rx_ready = 1'b1;
          if (rx_big) begin
            oversize_hit[rx_chan] = 1'b1;                           // [R8]
          end else begin
            next_mbox                = SCDF_DATA;                   // [R6]
            next_pending_channel_reg = rx_chan;                     // [R3]
            next_age_ms              = 16'h0000;
          end
        end else if (evt_valid && clk_en) begin
          evt_ready                = 1'b1;
          next_mbox                = SCDF_EVT;                      // [R10]
          next_pending_channel_reg = evt_chan;                      // [R3]
        end
      end
      SCDF_DATA: begin
        if (cmd_wr && pwdata[1:0] == CMD_RECEIVE) begin
          rx_consume = 1'b1;                                        // [R7] [R9]
          next_mbox  = SCDF_IDLE;
        end else if (expired) begin
          rx_drop                          = 1'b1;                  // [R20]
          timeout_hit[pending_channel_reg] = 1'b1;
          next_mbox                        = SCDF_IDLE;
        end
      end
      SCDF_EVT: begin
        if (cmd_wr && pwdata[1:0] == CMD_GETEVT) begin
          next_mbox = SCDF_IDLE;
        end
      end
      default: next_mbox = SCDF_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbox                <= SCDF_IDLE;
      pending_channel_reg <= '0;
      age_ms              <= 16'h0000;
      timeout_ms          <= TIMEOUT_RESET;
      small_buf           <= 1'b0;
    end else if (clk_en) begin
      mbox                <= next_mbox;
      pending_channel_reg <= next_pending_channel_reg;
      age_ms              <= next_age_ms;
      timeout_ms          <= next_timeout_ms;
      small_buf           <= next_small_buf;
    end
  end
  logic rx_data_flag, conn_event_flag;
  assign rx_data_flag    = (mbox == SCDF_DATA);                     // [R6]
  assign conn_event_flag = (mbox == SCDF_EVT);                      // [R10]
  ////////////////////////////////////////////////////////////////////////////
  // transmit path
  logic                send_busy_flag, next_send_busy_flag, tx_big;
  logic [CHAN_W-1:0]   tx_owner, next_tx_owner;
  logic [NUM_CHAN-1:0] chan_tx_active, refuse_hit, badlen_hit, ok_hit;
  assign tx_big = tx_len > buf_lim;
  always_comb begin
    next_send_busy_flag = send_busy_flag;
    next_tx_owner       = tx_owner;
    tx_accept           = 1'b0;
    refuse_hit          = '0;
    badlen_hit          = '0;
    ok_hit              = '0;
    if (send_busy_flag && (tx_done || tx_fail)) begin
      next_send_busy_flag = 1'b0;
      ok_hit[tx_owner]    = tx_done;
    end
    if (tx_req && clk_en) begin
      if (send_busy_flag) begin
        refuse_hit[tx_chan] = 1'b1;                                 // [R5] [R14]
      end else if (!tx_ctl && tx_big) begin
        badlen_hit[tx_chan] = 1'b1;                                 // [R8]
      end else if (tx_ctl) begin
        tx_accept       = 1'b1;
        ok_hit[tx_chan] = 1'b1;
      end else begin
        tx_accept           = 1'b1;
        next_send_busy_flag = 1'b1;                                 // [R5]
        next_tx_owner       = tx_chan;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_busy_flag <= 1'b0;
      tx_owner       <= '0;
    end else if (clk_en) begin
      send_busy_flag <= next_send_busy_flag;
      tx_owner       <= next_tx_owner;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // per-channel flags and detail registers
  logic [NUM_CHAN-1:0] rx_error_summary, tx_error_summary, cmd_not_done, chan_connected;
  logic [31:0]         detail [NUM_CHAN];
  assign chan_connected = conn_state;                               // [R15]
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_ch
      logic [31:0] err_set;
      logic        next_nd, fail;
      assign chan_tx_active[gi] = send_busy_flag && (tx_owner == CHAN_W'(gi));   // [R14]
      assign fail = refuse_hit[gi] || badlen_hit[gi] || (send_busy_flag && tx_fail
                    && tx_owner == CHAN_W'(gi));
      always_comb begin
        err_set                 = 32'h0000_0000;
        err_set[DB_RD_TIMEOUT]  = timeout_hit[gi];                  // [R20]
        err_set[DB_OVERSIZE]    = oversize_hit[gi] | rx_err_evt[gi];
        err_set[DB_TX_ILLEGAL]  = refuse_hit[gi] | badlen_hit[gi];
        err_set[DB_TX_ABSENT]   = tx_dest_evt[gi];
        // failure in the same cycle as success wins
        next_nd = fail || (cmd_not_done[gi] && !ok_hit[gi]);        // [R16]
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmd_not_done[gi] <= 1'b0;
        end else if (clk_en) begin
          cmd_not_done[gi] <= next_nd;
        end
      end
      scdf_chan_diag u_diag (
        .pclk             (pclk),
        .presetn          (presetn),
        .clk_en           (clk_en),
        .err_set          (err_set),
        .clr_we           (wr && hit_detail && sel_ch == CHAN_W'(gi)),
        .clr_mask         (pwdata),
        .detail           (detail[gi]),
        .rx_error_summary (rx_error_summary[gi]),
        .tx_error_summary (tx_error_summary[gi])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // apb read data
  logic [31:0] next_prdata, rd_val;
  logic        unmapped;
  always_comb begin
    rd_val   = 32'h0000_0000;                                       // [R21]
    unmapped = 1'b0;
    if (paddr == OFS_GLOBAL) begin
      rd_val[GF_SEND_BUSY] = send_busy_flag;
      rd_val[GF_RX_DATA]   = rx_data_flag;
      rd_val[GF_CONN_EVT]  = conn_event_flag;
      rd_val[GF_LINK_UP]   = link_up_flag;
    end else if (paddr == OFS_CHANREG) begin
      rd_val[CHAN_W-1:0] = pending_channel_reg;                     // [R3]
    end else if (paddr == OFS_TIMEOUT) begin
      rd_val[15:0] = timeout_ms;
    end else if (paddr == OFS_CONFIG) begin
      rd_val[0] = small_buf;
    end else if (hit_cflags) begin
      rd_val[CF_RX_ERR]  = rx_error_summary[sel_ch];
      rd_val[CF_TX_ACT]  = chan_tx_active[sel_ch];
      rd_val[CF_TX_ERR]  = tx_error_summary[sel_ch];
      rd_val[CF_CONN]    = chan_connected[sel_ch];
      rd_val[CF_NOTDONE] = cmd_not_done[sel_ch];
    end else if (hit_detail) begin
      rd_val = detail[sel_ch];
    end else if (paddr != OFS_CMD) begin
      unmapped = 1'b1;
    end
    pslverr     = acc && unmapped;
    // loaded in setup cycle, stands through access
    next_prdata = (psel && !penable && !pwrite && clk_en) ? rd_val : prdata;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_EXCL: assert property (@(posedge pclk) disable iff (!presetn)       // [R2]
    !(rx_data_flag && conn_event_flag)) else $error("data and event flags both set");
  AST_RECV_FREE: assert property (@(posedge pclk) disable iff (!presetn)  // [R7]
    (clk_en && rx_data_flag && cmd_wr && pwdata[1:0] == CMD_RECEIVE) |=> !rx_data_flag)
    else $error("receive command did not free mailbox");
  AST_BUSY_REFUSE: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    send_busy_flag |-> !(tx_accept && !tx_ctl)) else $error("send accepted while busy");
  AST_CHREG: assert property (@(posedge pclk) disable iff (!presetn)      // [R3]
    (clk_en && mbox == SCDF_IDLE && rx_valid && !rx_big) |=> pending_channel_reg == $past(rx_chan))
    else $error("channel register not loaded");
  AST_LINK: assert property (@(posedge pclk) disable iff (!presetn)       // [R11]
    (clk_en && $past(clk_en) && $past(clk_en, 2)) |-> link_up_flag == $past(link_pin, 2))
    else $error("link flag wrong");
  AST_TIMEOUT: assert property (@(posedge pclk) disable iff (!presetn)    // [R20]
    (clk_en && expired && !cmd_wr) |=> (!rx_data_flag && detail[$past(pending_channel_reg)][0]))
    else $error("timeout not handled");
  AST_RXSUM: assert property (@(posedge pclk) disable iff (!presetn)      // [R12]
    (clk_en && oversize_hit[4]) |=> rx_error_summary[4]) else $error("rx summary not raised");
  AST_UNUSED: assert property (@(posedge pclk) disable iff (!presetn)     // [R21]
    (detail[1] & ~DET_MASK) == 32'h0000_0000) else $error("unused detail bit set");
  AST_ND: assert property (@(posedge pclk) disable iff (!presetn)         // [R16]
    (clk_en && refuse_hit[7]) |=> cmd_not_done[7]) else $error("not-done not set");
endmodule
`default_nettype wire

// ---- verif/socket_channel_diag_flags_test.sv ----
// socket_channel_diag_flags_test: apb register tests for the channel flag bank
// assumes scdf_top with a short ms tick; bench drives every port itself
`default_nettype none
module socket_channel_diag_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scdf_pkg::*;
  logic                pclk, presetn, clk_en, psel, penable, pwrite, link_pin;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                pready, pslverr, last_err, acc;
  logic                rx_valid, rx_ready, evt_valid, evt_ready, tx_req, tx_ctl, tx_accept;
  logic [CHAN_W-1:0]   rx_chan, evt_chan, tx_chan;
  logic [LEN_W:0]      rx_len, tx_len;
  logic                tx_done, tx_fail, rx_consume, rx_drop, saw_consume, saw_drop;
  logic [NUM_CHAN-1:0] conn_state, rx_err_evt, tx_dest_evt;
  int                  n_fail, samples_checked, n_rx, cyc;
  ////////////////////////////////////////////////////////////////
  scdf_top #(.CYC_PER_TICK(10)) scdf_top_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_pin(link_pin), .rx_valid(rx_valid), .rx_chan(rx_chan),
    .rx_len(rx_len), .rx_ready(rx_ready), .evt_valid(evt_valid), .evt_chan(evt_chan),
    .evt_ready(evt_ready), .tx_req(tx_req), .tx_chan(tx_chan), .tx_len(tx_len),
    .tx_ctl(tx_ctl), .tx_accept(tx_accept), .tx_done(tx_done), .tx_fail(tx_fail),
    .conn_state(conn_state), .rx_err_evt(rx_err_evt), .tx_dest_evt(tx_dest_evt),
    .rx_consume(rx_consume), .rx_drop(rx_drop));
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // handshake catchers: drop offers at the taking edge
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (rx_ready === 1'b1) begin
      rx_valid <= 1'b0;
      n_rx <= n_rx + 1;
    end
    if (evt_ready === 1'b1) evt_valid <= 1'b0;
    if (rx_consume === 1'b1) saw_consume <= 1'b1;
    if (rx_drop === 1'b1) saw_drop <= 1'b1;
    if (cyc == 20000) begin
      $display("[FAIL] %0t timeout", $time);
      n_fail = n_fail + 1;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    last_err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %b", $time, what, got);
    end
  endtask
  task automatic check_reg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    samples_checked++;
    if ((rd & m) !== e || last_err !== 1'b0) begin
      n_fail++;
      $display("[FAIL] %0t reg %h got %h want %h", $time, a, rd, e);
    end
  endtask
  task automatic offer_rx(input logic [CHAN_W-1:0] c, input logic [LEN_W:0] l);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_chan <= c;
    rx_len <= l;
    repeat (8) @(posedge pclk);
    rx_valid <= 1'b0;
  endtask
  task automatic tx_pulse(input logic [CHAN_W-1:0] c, input logic ctl, input logic exp);
    @(posedge pclk);
    tx_req <= 1'b1;
    tx_chan <= c;
    tx_ctl <= ctl;
    tx_len <= 12'h00A;
    @(negedge pclk);
    acc = tx_accept;
    @(posedge pclk);
    tx_req <= 1'b0;
    check1(acc, exp, "tx accept");
  endtask
  function automatic logic [11:0] cf(input int c);
    return OFS_CFLAGS + 12'(4 * c);
  endfunction
  function automatic logic [11:0] dt(input int c);
    return OFS_DETAIL + 12'(4 * c);
  endfunction
  task automatic conclude();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, link_pin, rx_valid, evt_valid, tx_req} = '0;
    {tx_ctl, tx_done, tx_fail, saw_consume, saw_drop, last_err, acc} = '0;
    {paddr, pwdata, rx_chan, rx_len, evt_chan, tx_chan, tx_len} = '0;
    {conn_state, rx_err_evt, tx_dest_evt} = '0;
    clk_en = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    n_rx = 0;
    cyc = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h0);
    check_reg(OFS_TIMEOUT, 32'h0000_FFFF, 32'h3E8);
    check_reg(dt(0), 32'hFFFF_FFFF, 32'h0);
    link_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h40);
    link_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h0);
    offer_rx(5'd3, 12'h600);
    check1(n_rx == 1, 1'b1, "rx taken");
    evt_valid <= 1'b1;
    evt_chan <= 5'd5;
    repeat (4) @(posedge pclk);
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h2);
    check_reg(OFS_CHANREG, 32'h1F, 32'h3);
    apb(1'b1, OFS_CMD, {30'h0, CMD_RECEIVE});
    repeat (4) @(posedge pclk);
    check1(saw_consume, 1'b1, "consume");
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h4);
    check_reg(OFS_CHANREG, 32'h1F, 32'h5);
    apb(1'b1, OFS_CMD, {30'h0, CMD_GETEVT});
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h0);
    offer_rx(5'd4, 12'h601);
    check_reg(dt(4), 32'hFFFF_FFFF, 32'h100);
    check_reg(cf(4), 32'hFFFF_FFFF, 32'h1);
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1'b1, dt(4), 32'hFFFF_FEFF);
    check_reg(dt(4), 32'hFFFF_FFFF, 32'h100);
    apb(1'b1, dt(4), 32'h0000_0100);
    check_reg(dt(4), 32'hFFFF_FFFF, 32'h0);
    check_reg(cf(4), 32'hFFFF_FFFF, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h1);
    offer_rx(5'd8, 12'h2D1);
    check_reg(dt(8), 32'hFFFF_FFFF, 32'h100);
    apb(1'b1, OFS_CONFIG, 32'h0);
    apb(1'b1, OFS_TIMEOUT, 32'h2);
    offer_rx(5'd9, 12'h00A);
    repeat (100) @(posedge pclk);
    check1(saw_drop, 1'b1, "drop");
    check_reg(dt(9), 32'hFFFF_FFFF, 32'h1);
    check_reg(cf(9), 32'h1, 32'h1);
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h0);
    tx_pulse(5'd2, 1'b0, 1'b1);
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h1);
    check_reg(cf(2), 32'h2, 32'h2);
    tx_pulse(5'd7, 1'b0, 1'b0);
    tx_pulse(5'd2, 1'b1, 1'b0);
    check_reg(dt(7), 32'hFFFF_FFFF, 32'h8000_0000);
    check_reg(cf(7), 32'h1F, 32'h14);
    @(posedge pclk);
    tx_done <= 1'b1;
    @(posedge pclk);
    tx_done <= 1'b0;
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h0);
    check_reg(cf(2), 32'h2, 32'h0);
    tx_pulse(5'd7, 1'b1, 1'b1);
    check_reg(cf(7), 32'h14, 32'h4);
    apb(1'b1, dt(7), 32'h8000_0000);
    check_reg(cf(7), 32'h4, 32'h0);
    @(posedge pclk);
    tx_dest_evt <= 32'h0000_0002;
    rx_err_evt <= 32'h0000_0400;
    @(posedge pclk);
    tx_dest_evt <= '0;
    rx_err_evt <= '0;
    check_reg(dt(1), 32'hFFFF_FFFF, 32'h0080_0000);
    check_reg(cf(1), 32'h5, 32'h4);
    check_reg(dt(10), 32'hFFFF_FFFF, 32'h100);
    check_reg(cf(10), 32'h5, 32'h1);
    conn_state <= 32'h0000_0040;
    check_reg(cf(6), 32'h8, 32'h8);
    conn_state <= '0;
    check_reg(cf(6), 32'h8, 32'h0);
    clk_en <= 1'b0;
    tx_pulse(5'd3, 1'b0, 1'b0);
    clk_en <= 1'b1;
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h0);
    check_reg(cf(3), 32'h16, 32'h0);
    apb(1'b1, OFS_GLOBAL, 32'hFFFF_FFFF);
    check_reg(OFS_GLOBAL, 32'hFFFF_FFFF, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    check1(last_err, 1'b1, "unmapped err");
    check1(rd === 32'h0, 1'b1, "unmapped data");
    conclude();
  end
endmodule
`default_nettype wire
